/* verilog/icsr_pkg.sv */
// Package for the interrupt control and status register slice.
// Assumes a 16-bit register port with one-cycle strobes and a single system clock.
package icsr_pkg;

    // ------------------------------------------------------------
    // Register offsets (word index on the register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ICSR_OFS_CTRL2   = 4'h0;
    localparam logic [3:0] ICSR_OFS_SOFT    = 4'h1;
    localparam logic [3:0] ICSR_OFS_HARD    = 4'h2;
    localparam logic [3:0] ICSR_OFS_PEND    = 4'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ICSR_BIT_GLOBAL_EN  = 15;
    localparam int ICSR_BIT_DIS_INSTR  = 14;
    localparam int ICSR_BIT_SW_TRAP_EN = 13;
    localparam int ICSR_BIT_ALTVT   = 8;
    localparam int ICSR_BIT_NVM     = 8;
    localparam int ICSR_BIT_LOOP    = 4;
    localparam int ICSR_BIT_PLL     = 0;
    localparam int ICSR_BIT_SW_HARD = 0;
    localparam int ICSR_LVL_LSB     = 8;
    localparam int ICSR_NUM_EXT     = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       ICSR_RST_GLOBAL_EN  = 1'h1;
    localparam logic       ICSR_RST_SW_TRAP_EN = 1'h0;
    localparam logic       ICSR_RST_ALT_TABLE  = 1'h0;
    localparam logic       ICSR_RST_DIS_INSTR  = 1'h0;
    localparam logic       ICSR_RST_FLAG       = 1'h0;
    localparam logic [2:0] ICSR_RST_POL    = 3'h0;
    localparam logic [3:0] ICSR_RST_LEVEL  = 4'h0;
    localparam logic [7:0] ICSR_RST_VECTOR = 8'h00;

    // ------------------------------------------------------------
    // Vector numbers
    // ------------------------------------------------------------
    localparam logic [7:0] ICSR_VEC_OSC_FAIL  = 8'h00;
    localparam logic [7:0] ICSR_VEC_ADDR_ERR  = 8'h01;
    localparam logic [7:0] ICSR_VEC_HARD_TRAP = 8'h02;
    localparam logic [7:0] ICSR_VEC_STACK_ERR = 8'h03;
    localparam logic [7:0] ICSR_VEC_MATH_ERR  = 8'h04;
    localparam logic [7:0] ICSR_VEC_SOFT_ERR  = 8'h06;
    localparam logic [7:0] ICSR_VEC_EXT_IRQ0  = 8'h08;
    localparam logic [7:0] ICSR_VEC_CAPTURE1  = 8'h09;
    localparam logic [7:0] ICSR_VEC_RESERVED  = 8'hFF;
    localparam logic [3:0] ICSR_TRAP_LEVEL    = 4'hF;
    localparam logic [3:0] ICSR_USER_MAX_LVL  = 4'h7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } icsr_bus_req_t;

    typedef struct packed {
        logic osc_fail;
        logic addr_err;
        logic hard_sw;
        logic stack_err;
        logic math_err;
        logic nvm_addr_err;
        logic loop_overflow;
        logic pll_unlock;
    } icsr_trap_ev_t;

endpackage : icsr_pkg

/* verilog/icsr_edge_det.sv */
// Edge detector with selectable polarity for one external interrupt pin.
// Assumes an asynchronous pin; two synchroniser stages precede the detector.
`timescale 1ns/1ps
module icsr_edge_det (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    input  wire logic falling,
    output logic      pulse
);
    logic sync_a;
    logic sync_b;
    logic last;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last   <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            last   <= sync_b;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse <= 1'b0;
        end else begin
            pulse <= falling ? (last & ~sync_b) : (~last & sync_b);
        end
    end
endmodule : icsr_edge_det

/* verilog/icsr_top.sv */
// Interrupt control and status register slice with trap flags and pending vector.
// Assumes the CPU core gives trap events as one-cycle pulses and the user source
// arbitration hands in its winning vector with its assigned priority.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module icsr_top #(
    parameter int NUM_EXT = icsr_pkg::ICSR_NUM_EXT
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire icsr_pkg::icsr_bus_req_t bus,
    output logic [15:0]                rdata,
    input  wire logic                  dis_instr_active,
    input  wire icsr_pkg::icsr_trap_ev_t trap_ev,
    input  wire logic [3:0]            cpu_level,
    input  wire logic                  user_req,
    input  wire logic [7:0]            user_vector,
    input  wire logic [3:0]            user_level,
    input  wire logic [NUM_EXT-1:0]    ext_irq_pin,
    output logic [NUM_EXT-1:0]         ext_irq_event,
    output logic                       irq_take,
    output logic                       trap_take,
    output logic [7:0]                 take_vector,
    output logic                       alt_vector_table_select,
    output logic                       software_trap_ctrl
);
    import icsr_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_EXT != ICSR_NUM_EXT) begin : g_bad_num_ext
        $error("icsr_top supports exactly three external inputs");
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic                global_irq_enable;
    logic [NUM_EXT-1:0]  ext_pol;
    logic                irq_disable_instr_active;
    logic                wr_ctrl;
    logic                wr_soft;
    logic                wr_hard;

    // Writes to the read-only pending register or to unmapped offsets decode to nothing.
    assign wr_ctrl = bus.wr && (bus.addr == ICSR_OFS_CTRL2);
    assign wr_soft = bus.wr && (bus.addr == ICSR_OFS_SOFT);
    assign wr_hard = bus.wr && (bus.addr == ICSR_OFS_HARD);

    // Each control field sits in a register of its own, loaded only by a control write.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            global_irq_enable <= ICSR_RST_GLOBAL_EN;
        end else if (wr_ctrl) begin
            global_irq_enable <= bus.wdata[ICSR_BIT_GLOBAL_EN];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            software_trap_ctrl <= ICSR_RST_SW_TRAP_EN;
        end else if (wr_ctrl) begin
            software_trap_ctrl <= bus.wdata[ICSR_BIT_SW_TRAP_EN];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alt_vector_table_select <= ICSR_RST_ALT_TABLE;
        end else if (wr_ctrl) begin
            alt_vector_table_select <= bus.wdata[ICSR_BIT_ALTVT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_pol <= ICSR_RST_POL;
        end else if (wr_ctrl) begin
            ext_pol <= bus.wdata[NUM_EXT-1:0];
        end
    end

    // The status bit follows the core one cycle late; user requests see the same copy.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_disable_instr_active <= ICSR_RST_DIS_INSTR;
        end else begin
            irq_disable_instr_active <= dis_instr_active;
        end
    end

    // ------------------------------------------------------------
    // External interrupt edge detection
    // ------------------------------------------------------------
    // A pin that is held high through reset shows one rising edge just after it.
    for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
        icsr_edge_det u_edge (
            .clk     (clk),
            .reset   (reset),
            .pin     (ext_irq_pin[i]),
            .falling (ext_pol[i]),
            .pulse   (ext_irq_event[i])
        );
    end

    // ------------------------------------------------------------
    // Sticky trap flags
    // ------------------------------------------------------------
    logic nvm_addr_err_flag;
    logic loop_stack_overflow_flag;
    logic aux_pll_unlock_flag;
    logic sw_hard_trap_flag;
    logic hard_sw_ok;

    // A software hard trap counts only while the software trap control allows it.
    assign hard_sw_ok = trap_ev.hard_sw && software_trap_ctrl;

    // An event in the cycle of a clearing write wins over the clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvm_addr_err_flag <= ICSR_RST_FLAG;
        end else begin
            nvm_addr_err_flag <= trap_ev.nvm_addr_err
                || (wr_soft ? bus.wdata[ICSR_BIT_NVM] : nvm_addr_err_flag);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loop_stack_overflow_flag <= ICSR_RST_FLAG;
        end else begin
            loop_stack_overflow_flag <= trap_ev.loop_overflow
                || (wr_soft ? bus.wdata[ICSR_BIT_LOOP] : loop_stack_overflow_flag);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aux_pll_unlock_flag <= ICSR_RST_FLAG;
        end else begin
            aux_pll_unlock_flag <= trap_ev.pll_unlock
                || (wr_soft ? bus.wdata[ICSR_BIT_PLL] : aux_pll_unlock_flag);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_hard_trap_flag <= ICSR_RST_FLAG;
        end else begin
            sw_hard_trap_flag <= hard_sw_ok
                || (wr_hard ? bus.wdata[ICSR_BIT_SW_HARD] : sw_hard_trap_flag);
        end
    end

    // ------------------------------------------------------------
    // Trap and interrupt selection
    // ------------------------------------------------------------
    logic       trap_any;
    logic [7:0] trap_vec;
    logic       user_ok;
    logic [7:0] next_vector;
    logic [3:0] next_level;

    // Traps are ranked in a fixed order and always beat a user request.
    always_comb begin
        trap_any = 1'b1;
        trap_vec = ICSR_VEC_SOFT_ERR;
        if (trap_ev.osc_fail) begin
            trap_vec = ICSR_VEC_OSC_FAIL;
        end else if (trap_ev.addr_err) begin
            trap_vec = ICSR_VEC_ADDR_ERR;
        end else if (hard_sw_ok) begin
            trap_vec = ICSR_VEC_HARD_TRAP;
        end else if (trap_ev.stack_err) begin
            trap_vec = ICSR_VEC_STACK_ERR;
        end else if (trap_ev.math_err) begin
            trap_vec = ICSR_VEC_MATH_ERR;
        end else if (trap_ev.nvm_addr_err || trap_ev.loop_overflow || trap_ev.pll_unlock) begin
            trap_vec = ICSR_VEC_SOFT_ERR;
        end else begin
            trap_any = 1'b0;
        end
    end

    // User request must be a peripheral vector, never reserved, and above CPU level.
    assign user_ok = user_req && global_irq_enable && !irq_disable_instr_active
        && (cpu_level <= ICSR_USER_MAX_LVL)
        && (user_vector >= ICSR_VEC_EXT_IRQ0)
        && (user_vector != ICSR_VEC_RESERVED)
        && (user_level > cpu_level);

    // With nothing selected the latch holds, so these defaults never load.
    always_comb begin
        next_vector = ICSR_RST_VECTOR;
        next_level  = ICSR_RST_LEVEL;
        if (trap_any) begin
            next_vector = trap_vec;
            next_level  = ICSR_TRAP_LEVEL;
        end else if (user_ok) begin
            next_vector = user_vector;
            next_level  = user_level;
        end
    end

    // ------------------------------------------------------------
    // Pending vector and level latch
    // ------------------------------------------------------------
    logic [7:0] pending_vector_number;
    logic [3:0] new_priority_level;

    // Take outputs follow the selection one cycle late and stay high for as long as a request stays valid.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_take  <= 1'b0;
            trap_take <= 1'b0;
        end else begin
            irq_take  <= user_ok && !trap_any;
            trap_take <= trap_any;
        end
    end

    // Vector and level load together so that software never reads a mixed pair.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_vector_number <= ICSR_RST_VECTOR;
            new_priority_level    <= ICSR_RST_LEVEL;
            take_vector           <= ICSR_RST_VECTOR;
        end else if (trap_any || user_ok) begin
            pending_vector_number <= next_vector;
            new_priority_level    <= next_level;
            take_vector           <= next_vector;
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    // Read data stand only in the cycle after the read strobe and are zero otherwise.
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        case (bus.addr)
            ICSR_OFS_CTRL2: begin
                next_rdata[ICSR_BIT_GLOBAL_EN]  = global_irq_enable;
                next_rdata[ICSR_BIT_DIS_INSTR]  = irq_disable_instr_active;
                next_rdata[ICSR_BIT_SW_TRAP_EN] = software_trap_ctrl;
                next_rdata[ICSR_BIT_ALTVT]  = alt_vector_table_select;
                next_rdata[NUM_EXT-1:0]     = ext_pol;
            end
            ICSR_OFS_SOFT: begin
                next_rdata[ICSR_BIT_NVM]  = nvm_addr_err_flag;
                next_rdata[ICSR_BIT_LOOP] = loop_stack_overflow_flag;
                next_rdata[ICSR_BIT_PLL]  = aux_pll_unlock_flag;
            end
            ICSR_OFS_HARD: begin
                next_rdata[ICSR_BIT_SW_HARD] = sw_hard_trap_flag;
            end
            ICSR_OFS_PEND: begin
                next_rdata[ICSR_LVL_LSB +: 4] = new_priority_level;
                next_rdata[7:0]               = pending_vector_number;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule : icsr_top

/* bench/icsr_chk_assertions.sv */
// Concurrent checks on the ports of the interrupt control and status slice.
// Assumes one clock and an active high asynchronous reset.
`timescale 1ns/1ps
module icsr_chk #(
    parameter int NUM_EXT = 3
) (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire icsr_pkg::icsr_bus_req_t bus,
    input wire logic [15:0]             rdata,
    input wire icsr_pkg::icsr_trap_ev_t trap_ev,
    input wire logic [3:0]              cpu_level,
    input wire logic [7:0]              user_vector,
    input wire logic [NUM_EXT-1:0]      ext_irq_pin,
    input wire logic [NUM_EXT-1:0]      ext_irq_event,
    input wire logic                    irq_take,
    input wire logic                    trap_take,
    input wire logic [7:0]              take_vector,
    input wire logic                    software_trap_ctrl
);
    import icsr_pkg::*;
    // Shadow copies of the written enable and polarity bits.
    logic       glb_en;
    logic [2:0] pol;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            glb_en <= 1'h1;
            pol <= 3'h0;
        end else if (bus.wr && bus.addr == ICSR_OFS_CTRL2) begin
            glb_en <= bus.wdata[15];
            pol <= bus.wdata[2:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_osc_vector: assert property (trap_ev.osc_fail |=> trap_take && take_vector == 8'h00)
        else $error("oscillator trap not taken on vector zero");
    chk_soft_vector: assert property (trap_ev[7:3] == 5'h00 && trap_ev[2:0] != 3'h0
        |=> trap_take && take_vector == 8'h06) else $error("soft trap vector wrong");
    chk_hard_gated: assert property (trap_ev == 8'h20 && !software_trap_ctrl |=> !trap_take)
        else $error("software hard trap taken while disabled");
    chk_level_block: assert property (cpu_level > 4'h7 |=> !irq_take)
        else $error("user interrupt taken above level seven");
    chk_user_vector: assert property (irq_take |-> take_vector == $past(user_vector))
        else $error("taken vector differs from offered vector");
    chk_reserved_vec: assert property (user_vector == 8'hFF |=> !irq_take)
        else $error("reserved vector taken");
    chk_global_off: assert property (!glb_en |=> !irq_take)
        else $error("user interrupt taken while globally disabled");
    chk_edge_pulse: assert property (($rose(ext_irq_pin[0]) && !pol[0])
        || ($fell(ext_irq_pin[0]) && pol[0]) |-> ##[1:6] ext_irq_event[0])
        else $error("selected edge gave no event");
    chk_soft_unused: assert property ($past(bus.rd && bus.addr == ICSR_OFS_SOFT)
        |-> (rdata & 16'hFEEE) == 16'h0000) else $error("unused soft status bits set");
    cov_trap: cover property (trap_take);
    cov_irq: cover property (irq_take);
    cov_edge: cover property (ext_irq_event[0]);
endmodule : icsr_chk

bind icsr_top icsr_chk #(.NUM_EXT(NUM_EXT)) icsr_chk_i (.clk, .reset, .bus, .rdata, .trap_ev,
    .cpu_level, .user_vector, .ext_irq_pin, .ext_irq_event, .irq_take, .trap_take,
    .take_vector, .software_trap_ctrl);

/* bench/icsr_core_model.sv */
// Model of the CPU core and the user source arbiter facing the slice.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ps
module icsr_core_model (
    input  wire logic              clk,
    output icsr_pkg::icsr_trap_ev_t trap_ev,
    output logic                   dis_instr_active,
    output logic [3:0]             cpu_level,
    output logic                   user_req,
    output logic [7:0]             user_vector,
    output logic [3:0]             user_level
);
    import icsr_pkg::*;
    initial begin
        trap_ev = '0;
        dis_instr_active = 1'b0;
        cpu_level = 4'h0;
        user_req = 1'b0;
        user_vector = 8'h5A;
        user_level = 4'h0;
    end
    task automatic fire_trap(input icsr_trap_ev_t ev);
        @(posedge clk);
        trap_ev <= ev;
        @(posedge clk);
        trap_ev <= '0;
    endtask : fire_trap
    // The vector and level are scrambled once the request is withdrawn.
    task automatic offer(input logic [7:0] vec, input logic [3:0] lvl);
        @(posedge clk);
        user_req <= 1'b1;
        user_vector <= vec;
        user_level <= lvl;
        @(posedge clk);
        user_req <= 1'b0;
        user_vector <= ~vec;
        user_level <= ~lvl;
    endtask : offer
    task automatic set_core(input logic dis, input logic [3:0] lvl);
        @(posedge clk);
        dis_instr_active <= dis;
        cpu_level <= lvl;
    endtask : set_core
endmodule : icsr_core_model

/* bench/test_interrupt_control_status_regs.sv */
// Self-checking bench for the interrupt control and status slice.
// Assumes the core model drives the core side and the checker is bound.
`timescale 1ns/1ps
module test_interrupt_control_status_regs;
    import icsr_pkg::*;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    icsr_bus_req_t bus = '0;
    logic [2:0]    ext_irq_pin = 3'h0;
    logic [15:0]   rdata, d;
    logic [2:0]    ext_irq_event;
    logic          irq_take, trap_take, alt_vector_table_select, software_trap_ctrl;
    logic [7:0]    take_vector, v;
    icsr_trap_ev_t trap_ev;
    logic          dis_instr_active, user_req;
    logic [3:0]    cpu_level, user_level;
    logic [7:0]    user_vector;
    logic [15:0]   rd_q[$];
    logic [7:0]    tk_q[$];
    logic [7:0]    tab[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h06, 8'h06};
    logic          rd_pend = 1'b0;
    logic [31:0]   seed = 32'h0000004D;
    int            n_errors = 0;
    int            cmp_count = 0;
    int            cycles = 0;
    int            cnt;
    always #50 clk = ~clk;
    icsr_top icsr_top_i (.clk, .reset, .bus, .rdata, .dis_instr_active, .trap_ev, .cpu_level,
        .user_req, .user_vector, .user_level, .ext_irq_pin, .ext_irq_event, .irq_take,
        .trap_take, .take_vector, .alt_vector_table_select, .software_trap_ctrl);
    icsr_core_model icsr_core_model_i (.clk, .trap_ev, .dis_instr_active, .cpu_level, .user_req,
        .user_vector, .user_level);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic wr(input logic [3:0] a, input logic [15:0] wd);
        @(posedge clk);
        bus <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
    endtask : rd
    task automatic drain();
        repeat (4) @(posedge clk);
        check(16'(tk_q.size()), 16'h0000);
    endtask : drain
    task automatic watch(input int i);
        cnt = 0;
        repeat (8) @(negedge clk) cnt += int'(ext_irq_event[i]);
        @(posedge clk);
    endtask : watch
    task automatic results();
        $display("compared %0d, mismatched %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    // Results are compared against the oldest note as they appear.
    always @(negedge clk) begin
        if (rd_pend) check(rdata, rd_q.size() ? rd_q.pop_front() : 16'hDEAD);
        if (trap_take || irq_take) check({8'h00, take_vector},
            tk_q.size() ? {8'h00, tk_q.pop_front()} : 16'hDEAD);
        rd_pend = bus.rd;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(ICSR_OFS_CTRL2, 16'h8000);
        rd(ICSR_OFS_SOFT, 16'h0000);
        rd(ICSR_OFS_HARD, 16'h0000);
        rd(ICSR_OFS_PEND, 16'h0000);
        rd(4'h9, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            d = 16'(rnd());
            wr(ICSR_OFS_CTRL2, d);
            @(negedge clk);
            check({14'h0, software_trap_ctrl, alt_vector_table_select}, {14'h0, d[13], d[8]});
            rd(ICSR_OFS_CTRL2, d & 16'hA107);
        end
        wr(ICSR_OFS_PEND, 16'hFFFF);
        rd(ICSR_OFS_PEND, 16'h0000);
        wr(ICSR_OFS_CTRL2, 16'h8000);
        icsr_core_model_i.set_core(1'b1, 4'h0);
        rd(ICSR_OFS_CTRL2, 16'hC000);
        icsr_core_model_i.offer(8'h08, 4'h3);
        icsr_core_model_i.set_core(1'b0, 4'h0);
        $display("control test done");
        for (int i = 0; i < 8; i++) begin
            if (i != 2) tk_q.push_back(tab[i]);
            icsr_core_model_i.fire_trap(8'h80 >> i);
        end
        drain();
        rd(ICSR_OFS_SOFT, 16'h0111);
        rd(ICSR_OFS_HARD, 16'h0000);
        rd(ICSR_OFS_PEND, 16'h0F06);
        wr(ICSR_OFS_CTRL2, 16'h2000);
        tk_q.push_back(8'h02);
        icsr_core_model_i.fire_trap(8'h20);
        tk_q.push_back(8'h00);
        icsr_core_model_i.fire_trap(8'h98);
        drain();
        rd(ICSR_OFS_HARD, 16'h0001);
        rd(ICSR_OFS_PEND, 16'h0F00);
        wr(ICSR_OFS_SOFT, 16'h0000);
        wr(ICSR_OFS_HARD, 16'h0000);
        rd(ICSR_OFS_SOFT, 16'h0000);
        rd(ICSR_OFS_HARD, 16'h0000);
        $display("trap test done");
        wr(ICSR_OFS_CTRL2, 16'h8000);
        tk_q.push_back(8'h08);
        icsr_core_model_i.offer(8'h08, 4'h3);
        rd(ICSR_OFS_PEND, 16'h0308);
        for (int i = 0; i < 3; i++) begin
            v = 8'h09 + 8'(rnd() % 200);
            tk_q.push_back(v);
            icsr_core_model_i.offer(v, 4'h1 + 4'(rnd() % 7));
        end
        icsr_core_model_i.offer(8'hFF, 4'h3);
        icsr_core_model_i.set_core(1'b0, 4'h8);
        icsr_core_model_i.offer(8'h08, 4'hF);
        icsr_core_model_i.set_core(1'b0, 4'h0);
        wr(ICSR_OFS_CTRL2, 16'h0000);
        icsr_core_model_i.offer(8'h08, 4'h3);
        drain();
        $display("user test done");
        for (int p = 0; p < 2; p++) begin
            wr(ICSR_OFS_CTRL2, p ? 16'h8007 : 16'h8000);
            for (int i = 0; i < 3; i++) begin
                ext_irq_pin[i] <= 1'b1;
                watch(i);
                check(16'(cnt), 16'(1 - p));
                ext_irq_pin[i] <= 1'b0;
                watch(i);
                check(16'(cnt), 16'(p));
            end
        end
        $display("edge test done");
        results();
    end
endmodule : test_interrupt_control_status_regs
